// ---- design/tfsc_pkg.sv ----
// Shared constants and types for the transmitter front-end and synthesizer
// calibration register bank.
// Assumes a 100 MHz aclk and an AXI4-Lite master with 32-bit data.
package tfsc_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 10;
	localparam int RAMP_STEP_NS     = 100;
	localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAL_STAGE_NS     = 1000;
	localparam int CAL_STAGE_CYCLES = (CAL_STAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W            = 8;

	// ------------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------------
	localparam int          IDX_W                   = 10;
	localparam logic [9:0]  IDX_TX_FRONT_END_CONFIG = 10'h022;
	localparam logic [9:0]  IDX_SYNTH_CHARGE_PUMP   = 10'h023;
	localparam logic [9:0]  IDX_SYNTH_VCO_CURRENT   = 10'h024;
	localparam logic [9:0]  IDX_SYNTH_VCO_CAPACITOR = 10'h025;
	localparam logic [9:0]  IDX_AMP_TABLE_BASE      = 10'h040;
	localparam logic [9:0]  IDX_STATUS              = 10'h048;
	localparam int          AMP_TABLE_DEPTH         = 8;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int FE_LO_BUF_MSB   = 5;
	localparam int FE_LO_BUF_LSB   = 4;
	localparam int FE_LEVEL_MSB    = 2;
	localparam int FE_LEVEL_LSB    = 0;
	localparam int CP_CONFIG_MSB   = 7;
	localparam int CP_CONFIG_LSB   = 6;
	localparam int CP_ENABLE_MSB   = 5;
	localparam int CP_ENABLE_LSB   = 4;
	localparam int CP_RESULT_MSB   = 3;
	localparam int CP_RESULT_LSB   = 0;
	localparam int VCO_CURRENT_MSB = 5;
	localparam int VCO_HIGH_BIT    = 5;
	localparam int VCO_CAP_MSB     = 5;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [1:0] FE_LO_BUF_RST   = 2'h1;
	localparam logic [2:0] FE_LEVEL_RST    = 3'h0;
	localparam logic [1:0] CP_CONFIG_RST   = 2'h2;
	localparam logic [1:0] CP_ENABLE_RST   = 2'h2;
	localparam logic [3:0] CP_RESULT_RST   = 4'h9;
	localparam logic [5:0] VCO_CURRENT_RST = 6'h0a;
	localparam logic [5:0] VCO_CAP_RST     = 6'h20;
	localparam logic [7:0] AMP_TABLE_RST   = 8'h00;

	// ------------------------------------------------------------------
	// Bus responses and state types
	// ------------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {AMP_OFF, AMP_RAMP, AMP_HOLD} tfsc_amp_state_t;
	typedef enum logic [1:0] {CAL_IDLE, CAL_PUMP, CAL_VCO} tfsc_cal_state_t;

endpackage : tfsc_pkg

// ---- design/tfsc_amp_seq.sv ----
// Amplifier table index sequencer: ramps and shapes the table index.
// Assumes level and mode inputs are synchronous to aclk.
`timescale 1ns/1ps
module tfsc_amp_seq (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        tx_active,
	input  wire logic        ask_mode,
	input  wire logic        tx_symbol,
	input  wire logic [2:0]  level_index,
	output logic      [2:0]  table_index,
	output logic             amp_on
);
	logic [2:0]               target;
	logic [tfsc_pkg::CNT_W-1:0] step_cnt_q;
	logic                     tick;
	tfsc_pkg::tfsc_amp_state_t state;

	// Zero symbol in keying mode and end of frame both aim at entry zero
	always_comb begin
		target = (!tx_active || (ask_mode && !tx_symbol)) ? 3'h0 : level_index;
		tick   = (step_cnt_q == '0);
	end

	// Step pacing; one table entry per step keeps the spectrum clean
	always_ff @(posedge aclk) begin
		if (!aresetn || tick) begin
			step_cnt_q <= tfsc_pkg::CNT_W'(tfsc_pkg::RAMP_STEP_CYCLES - 1);
		end else begin
			step_cnt_q <= step_cnt_q - 1'b1;
		end
	end

	// Walk one entry toward the target per step
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			table_index <= 3'h0;
		end else if (tick && table_index < target) begin
			table_index <= table_index + 3'h1;
		end else if (tick && table_index > target) begin
			table_index <= table_index - 3'h1;
		end
	end

	// Amplifier stays on until the ramp-down has reached entry zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			amp_on <= 1'b0;
		end else begin
			amp_on <= tx_active || (table_index != 3'h0);
		end
	end

	always_comb begin
		if (!tx_active && table_index == 3'h0) begin
			state = tfsc_pkg::AMP_OFF;
		end else if (table_index == target) begin
			state = tfsc_pkg::AMP_HOLD;
		end else begin
			state = tfsc_pkg::AMP_RAMP;
		end
	end

	AST_STEP_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
		1 |=> (table_index == $past(table_index)) || (table_index == $past(table_index) + 3'h1)
			|| (table_index == $past(table_index) - 3'h1))
		else $error("Table index jumped more than one entry");

	AST_ASK_ZERO_STAYS: assert property (@(posedge aclk) disable iff (!aresetn)
		(tx_active && ask_mode && !tx_symbol && state == tfsc_pkg::AMP_HOLD) |=> table_index == 3'h0)
		else $error("Zero symbol left entry zero");

	AST_RAMP_UP: assert property (@(posedge aclk) disable iff (!aresetn)
		(tick && tx_active && !(ask_mode && !tx_symbol) && table_index < level_index)
		|=> table_index == $past(table_index) + 3'h1)
		else $error("Ramp toward level did not advance");

endmodule : tfsc_amp_seq

// ---- design/tfsc_cal_seq.sv ----
// Synthesizer calibration stage sequencer.
// Assumes a one-cycle start pulse; results are sampled by the register bank.
`timescale 1ns/1ps
module tfsc_cal_seq (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        cal_start,
	input  wire logic [1:0]  pump_enable,
	output logic             busy,
	output logic             pump_done,
	output logic             vco_done
);
	tfsc_pkg::tfsc_cal_state_t  state_q;
	logic [tfsc_pkg::CNT_W-1:0] cnt_q;
	logic                       stage_end;

	assign stage_end = (cnt_q == '0);
	assign busy      = (state_q != tfsc_pkg::CAL_IDLE);

	// Stage walk; a zero enable skips the pump stage entirely
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q   <= tfsc_pkg::CAL_IDLE;
			cnt_q     <= '0;
			pump_done <= 1'b0;
			vco_done  <= 1'b0;
		end else begin
			pump_done <= 1'b0;
			vco_done  <= 1'b0;
			case (state_q)
				tfsc_pkg::CAL_IDLE: begin
					if (cal_start) begin
						state_q <= (pump_enable != 2'h0) ? tfsc_pkg::CAL_PUMP
							: tfsc_pkg::CAL_VCO;
						cnt_q   <= tfsc_pkg::CNT_W'(tfsc_pkg::CAL_STAGE_CYCLES - 1);
					end
				end
				tfsc_pkg::CAL_PUMP: begin
					if (stage_end) begin
						state_q   <= tfsc_pkg::CAL_VCO;
						cnt_q     <= tfsc_pkg::CNT_W'(tfsc_pkg::CAL_STAGE_CYCLES - 1);
						pump_done <= 1'b1;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				tfsc_pkg::CAL_VCO: begin
					if (stage_end) begin
						state_q  <= tfsc_pkg::CAL_IDLE;
						vco_done <= 1'b1;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				default: begin
					state_q <= tfsc_pkg::CAL_IDLE;
				end
			endcase
		end
	end

	AST_PUMP_SKIPPED: assert property (@(posedge aclk) disable iff (!aresetn)
		(!busy && cal_start && pump_enable == 2'h0) |=> state_q == tfsc_pkg::CAL_VCO)
		else $error("Pump stage ran while disabled");

	AST_PUMP_RUN: assert property (@(posedge aclk) disable iff (!aresetn)
		(!busy && cal_start && pump_enable != 2'h0) |=> state_q == tfsc_pkg::CAL_PUMP)
		else $error("Pump stage did not start");

endmodule : tfsc_cal_seq

// ---- design/tfsc_regs.sv ----
// Transmitter front-end and synthesizer calibration register bank, AXI4-Lite slave.
// Assumes a single-clock system; radio controls arrive synchronous to aclk.
//
// Overview of operation
// - Level index selects one of eight table entries
// - Keying one symbol uses entry at level index
// - Keying zero symbol uses table entry zero
// - Step entries zero to level for ramps, shaping
// - Buffer current field, two bits, resets to one
// - Zero pump enable skips pump calibration stage
// - Pump calibration result, four bits, resets nine
// - Written calibration values replace running calibration
// - High core select bit, resets to zero
// - VCO current result and override, resets ten
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module tfsc_regs (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Radio side
	input  wire logic        tx_active,
	input  wire logic        ask_mode,
	input  wire logic        tx_symbol,
	input  wire logic        cal_start,
	input  wire logic [3:0]  cal_pump_result,
	input  wire logic [5:0]  cal_vco_result,
	input  wire logic [5:0]  cal_cap_result,
	output logic [7:0]       amp_setting_q,
	output logic             amp_enable_q,
	output logic [1:0]       tx_lo_buffer_current_q,
	output logic [1:0]       synth_cal_config_q,
	output logic [3:0]       pump_current_q,
	output logic             vco_high_core_select_q,
	output logic [5:0]       vco_current_q,
	output logic [5:0]       vco_capacitor_q,
	output logic             cal_busy_q
);

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [1:0]  lo_buf_q;
	logic [2:0]  amp_level_index_q;
	logic [1:0]  cp_config_q;
	logic [1:0]  pump_cal_stage_enable_q;
	logic [3:0]  cp_result_q;
	logic [5:0]  vco_cur_q;
	logic [5:0]  vco_cap_q;
	logic [7:0]  amp_settings_table [tfsc_pkg::AMP_TABLE_DEPTH];

	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        do_write;
	logic [9:0]  wr_idx;
	logic        wr_lane0;

	logic [2:0]  seq_index;
	logic        seq_amp_on;
	logic        cal_busy;
	logic        pump_done;
	logic        vco_done;

	// ------------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------------
	// Index of an aligned byte address; misaligned ones map nowhere
	function automatic logic [9:0] addr_index(input logic [11:0] addr);
		addr_index = (addr[1:0] == 2'h0) ? addr[11:2] : 10'h3ff;
	endfunction : addr_index

	function automatic logic is_table(input logic [9:0] idx);
		is_table = (idx >= tfsc_pkg::IDX_AMP_TABLE_BASE)
			&& (idx < tfsc_pkg::IDX_AMP_TABLE_BASE + 10'(tfsc_pkg::AMP_TABLE_DEPTH));
	endfunction : is_table

	function automatic logic is_mapped(input logic [9:0] idx);
		if (idx == tfsc_pkg::IDX_TX_FRONT_END_CONFIG) begin
			is_mapped = 1'b1;
		end else if (idx == tfsc_pkg::IDX_SYNTH_CHARGE_PUMP) begin
			is_mapped = 1'b1;
		end else if (idx == tfsc_pkg::IDX_SYNTH_VCO_CURRENT) begin
			is_mapped = 1'b1;
		end else if (idx == tfsc_pkg::IDX_SYNTH_VCO_CAPACITOR) begin
			is_mapped = 1'b1;
		end else if (idx == tfsc_pkg::IDX_STATUS) begin
			is_mapped = 1'b1;
		end else begin
			is_mapped = is_table(idx);
		end
	endfunction : is_mapped

	// Read mux; unused positions are zero-filled
	function automatic logic [31:0] read_word(input logic [9:0] idx);
		logic [7:0] v;
		v = 8'h00;
		if (idx == tfsc_pkg::IDX_TX_FRONT_END_CONFIG) begin
			v = {2'h0, lo_buf_q, 1'b0, amp_level_index_q};
		end else if (idx == tfsc_pkg::IDX_SYNTH_CHARGE_PUMP) begin
			v = {cp_config_q, pump_cal_stage_enable_q, cp_result_q};
		end else if (idx == tfsc_pkg::IDX_SYNTH_VCO_CURRENT) begin
			v = {2'h0, vco_cur_q};
		end else if (idx == tfsc_pkg::IDX_SYNTH_VCO_CAPACITOR) begin
			v = {2'h0, vco_cap_q};
		end else if (idx == tfsc_pkg::IDX_STATUS) begin
			v = {3'h0, seq_amp_on, seq_index, cal_busy};
		end else if (is_table(idx)) begin
			v = amp_settings_table[idx[2:0]];
		end
		read_word = {24'h000000, v};
	endfunction : read_word

	// ------------------------------------------------------------------
	// AXI4-Lite write channels
	// ------------------------------------------------------------------
	// Address and data are held independently, so either may come first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			awaddr_q      <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			awaddr_q      <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b1;
			wdata_q      <= 32'h00000000;
			wstrb_q      <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			wdata_q      <= s_axi_wdata;
			wstrb_q      <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_idx   = addr_index(awaddr_q);
	assign wr_lane0 = do_write && wstrb_q[0];

	// Response once both halves are in; unmapped addresses get an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= tfsc_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= is_mapped(wr_idx) ? tfsc_pkg::RESP_OKAY : tfsc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read channels
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= tfsc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= read_word(addr_index(s_axi_araddr));
			s_axi_rresp   <= is_mapped(addr_index(s_axi_araddr)) ? tfsc_pkg::RESP_OKAY
				: tfsc_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Front-end configuration and amplifier table
	// ------------------------------------------------------------------
	// Only byte lane 0 carries register data; other lanes are ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lo_buf_q          <= tfsc_pkg::FE_LO_BUF_RST;
			amp_level_index_q <= tfsc_pkg::FE_LEVEL_RST;
		end else if (wr_lane0 && wr_idx == tfsc_pkg::IDX_TX_FRONT_END_CONFIG) begin
			lo_buf_q          <= wdata_q[tfsc_pkg::FE_LO_BUF_MSB:tfsc_pkg::FE_LO_BUF_LSB];
			amp_level_index_q <= wdata_q[tfsc_pkg::FE_LEVEL_MSB:tfsc_pkg::FE_LEVEL_LSB];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < tfsc_pkg::AMP_TABLE_DEPTH; i++) begin
				amp_settings_table[i] <= tfsc_pkg::AMP_TABLE_RST;
			end
		end else if (wr_lane0 && is_table(wr_idx)) begin
			amp_settings_table[wr_idx[2:0]] <= wdata_q[7:0];
		end
	end

	// ------------------------------------------------------------------
	// Calibration results; a host write is an override
	// ------------------------------------------------------------------
	// Host write wins over a result landing in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cp_config_q             <= tfsc_pkg::CP_CONFIG_RST;
			pump_cal_stage_enable_q <= tfsc_pkg::CP_ENABLE_RST;
			cp_result_q             <= tfsc_pkg::CP_RESULT_RST;
		end else if (wr_lane0 && wr_idx == tfsc_pkg::IDX_SYNTH_CHARGE_PUMP) begin
			cp_config_q             <= wdata_q[tfsc_pkg::CP_CONFIG_MSB:tfsc_pkg::CP_CONFIG_LSB];
			pump_cal_stage_enable_q <= wdata_q[tfsc_pkg::CP_ENABLE_MSB:tfsc_pkg::CP_ENABLE_LSB];
			cp_result_q             <= wdata_q[tfsc_pkg::CP_RESULT_MSB:tfsc_pkg::CP_RESULT_LSB];
		end else if (pump_done) begin
			cp_result_q <= cal_pump_result;
		end
	end

	// The core select is bit 5 of the current field, one shared flop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vco_cur_q <= tfsc_pkg::VCO_CURRENT_RST;
		end else if (wr_lane0 && wr_idx == tfsc_pkg::IDX_SYNTH_VCO_CURRENT) begin
			vco_cur_q <= wdata_q[tfsc_pkg::VCO_CURRENT_MSB:0];
		end else if (vco_done) begin
			vco_cur_q <= cal_vco_result;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vco_cap_q <= tfsc_pkg::VCO_CAP_RST;
		end else if (wr_lane0 && wr_idx == tfsc_pkg::IDX_SYNTH_VCO_CAPACITOR) begin
			vco_cap_q <= wdata_q[tfsc_pkg::VCO_CAP_MSB:0];
		end else if (vco_done) begin
			vco_cap_q <= cal_cap_result;
		end
	end

	// ------------------------------------------------------------------
	// Sequencers
	// ------------------------------------------------------------------
	tfsc_amp_seq u_amp_seq (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.tx_active   (tx_active),
		.ask_mode    (ask_mode),
		.tx_symbol   (tx_symbol),
		.level_index (amp_level_index_q),
		.table_index (seq_index),
		.amp_on      (seq_amp_on)
	);

	// Calibration only runs on request; stored values drive the synthesizer otherwise
	tfsc_cal_seq u_cal_seq (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.cal_start   (cal_start),
		.pump_enable (pump_cal_stage_enable_q),
		.busy        (cal_busy),
		.pump_done   (pump_done),
		.vco_done    (vco_done)
	);

	// ------------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------------
	// One cycle of latency buys glitch-free analog control lines
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			amp_setting_q <= tfsc_pkg::AMP_TABLE_RST;
			amp_enable_q  <= 1'b0;
		end else begin
			amp_setting_q <= amp_settings_table[seq_index];
			amp_enable_q  <= seq_amp_on;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_lo_buffer_current_q <= tfsc_pkg::FE_LO_BUF_RST;
			synth_cal_config_q     <= tfsc_pkg::CP_CONFIG_RST;
			pump_current_q         <= tfsc_pkg::CP_RESULT_RST;
			vco_high_core_select_q <= tfsc_pkg::VCO_CURRENT_RST[tfsc_pkg::VCO_HIGH_BIT];
			vco_current_q          <= tfsc_pkg::VCO_CURRENT_RST;
			vco_capacitor_q        <= tfsc_pkg::VCO_CAP_RST;
			cal_busy_q             <= 1'b0;
		end else begin
			tx_lo_buffer_current_q <= lo_buf_q;
			synth_cal_config_q     <= cp_config_q;
			pump_current_q         <= cp_result_q;
			vco_high_core_select_q <= vco_cur_q[tfsc_pkg::VCO_HIGH_BIT];
			vco_current_q          <= vco_cur_q;
			vco_capacitor_q        <= vco_cap_q;
			cal_busy_q             <= cal_busy;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	AST_AMP_FROM_TABLE: assert property (@(posedge aclk) disable iff (!aresetn)
		1 |=> amp_setting_q == amp_settings_table[$past(seq_index)] || $past(wr_lane0))
		else $error("Amplifier setting not the indexed table entry");

	AST_LO_BUF_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_lane0 && wr_idx == tfsc_pkg::IDX_TX_FRONT_END_CONFIG)
		|=> ##1 tx_lo_buffer_current_q == $past(wdata_q[5:4], 2))
		else $error("Buffer current output missed the write");

	AST_PUMP_RESULT: assert property (@(posedge aclk) disable iff (!aresetn)
		(pump_done && !(wr_lane0 && wr_idx == tfsc_pkg::IDX_SYNTH_CHARGE_PUMP))
		|=> ##1 pump_current_q == $past(cal_pump_result, 2))
		else $error("Pump result not stored");

	AST_VCO_OVERRIDE: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_lane0 && wr_idx == tfsc_pkg::IDX_SYNTH_VCO_CURRENT && !cal_busy && !cal_start)
		|=> ##1 vco_current_q == $past(wdata_q[5:0], 2))
		else $error("Written VCO current not applied");

	AST_CORE_SHARED: assert property (@(posedge aclk) disable iff (!aresetn)
		1 |=> vco_high_core_select_q == vco_current_q[tfsc_pkg::VCO_HIGH_BIT])
		else $error("Core select differs from shared current bit");

	AST_UNUSED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready
			&& addr_index(s_axi_araddr) == tfsc_pkg::IDX_TX_FRONT_END_CONFIG)
		|=> s_axi_rvalid && s_axi_rdata[7:6] == 2'h0 && s_axi_rdata[3] == 1'b0)
		else $error("Unused front-end bits read nonzero");

endmodule : tfsc_regs

// ---- bench/tb.sv ----
// Self-checking bench for the front-end and synthesizer calibration register bank.
// Assumes the bank is the only AXI4-Lite slave and the bench drives the radio side itself.
`timescale 1ns/1ps
module tb;
	// ----------------------------------------------------------------
	// Signals, named as the ports they drive or watch
	// ----------------------------------------------------------------
	logic        aclk, aresetn, tx_active, ask_mode, tx_symbol, cal_start;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, tx_lo_buffer_current_q, synth_cal_config_q;
	logic        amp_enable_q, vco_high_core_select_q, cal_busy_q;
	logic [3:0]  cal_pump_result, pump_current_q;
	logic [5:0]  cal_vco_result, cal_cap_result, vco_current_q, vco_capacitor_q;
	logic [7:0]  amp_setting_q;
	int          fail_count, check_count, i, n;

	tfsc_regs dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_active,
		.ask_mode, .tx_symbol, .cal_start, .cal_pump_result, .cal_vco_result, .cal_cap_result,
		.amp_setting_q, .amp_enable_q, .tx_lo_buffer_current_q, .synth_cal_config_q,
		.pump_current_q, .vco_high_core_select_q, .vco_current_q, .vco_capacitor_q, .cal_busy_q
	);

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wrap_up();
		if (fail_count == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up

	// Every wait is bounded; a wait that runs out ends the run as a failure
	task automatic hung();
		fail_count++;
		$display("MISMATCH at %0t: wait ran out", $time);
		wrap_up();
	endtask : hung

	// ----------------------------------------------------------------
	// Bus tasks: payload held until taken, response checked at its edge
	// ----------------------------------------------------------------
	task automatic axw(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 50) hung();
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : axw

	task automatic axr(input logic [11:0] a, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		rd = s_axi_rdata;
		s_axi_rready <= 1'b0;
		if (n == 50) hung();
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask : axr

	// ----------------------------------------------------------------
	// Clock and test sequence
	// ----------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	initial begin
		{aresetn, tx_active, ask_mode, tx_symbol, cal_start} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{cal_pump_result, cal_vco_result, cal_cap_result} = '0;
		{fail_count, check_count} = '0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		axr(12'h088, 2'h0);
		chk(rd, 32'h10);
		chk({30'h0, tx_lo_buffer_current_q}, 32'h1);
		axr(12'h08c, 2'h0);
		chk(rd, 32'ha9);
		chk({28'h0, pump_current_q}, 32'h9);
		axr(12'h090, 2'h0);
		chk(rd, 32'h0a);
		chk({31'h0, vco_high_core_select_q}, 32'h0);
		// Unused bits, unmapped place, shared core bit
		axw(12'h088, 8'hff, 2'h0);
		axr(12'h088, 2'h0);
		chk(rd, 32'h37);
		axw(12'h0fc, 8'h55, 2'h2);
		axr(12'h0fc, 2'h2);
		chk(rd, 32'h0);
		axw(12'h090, 8'hff, 2'h0);
		axr(12'h090, 2'h0);
		chk(rd, 32'h3f);
		chk({31'h0, vco_high_core_select_q}, 32'h1);
		axw(12'h090, 8'h1a, 2'h0);
		repeat (2) @(posedge aclk);
		chk({31'h0, vco_high_core_select_q}, 32'h0);
		// Distinct table entries so every index shows at the amplifier
		for (i = 0; i < 8; i++) axw(12'(12'h100 + 4 * i), 8'(8'h40 + i), 2'h0);
		axw(12'h088, 8'h15, 2'h0);
		tx_active <= 1'b1;
		repeat (3) @(posedge aclk);
		chk({31'h0, amp_setting_q[7:1] == 7'h20}, 32'h1);
		repeat (100) @(posedge aclk);
		chk({23'h0, amp_enable_q, amp_setting_q}, 32'h145);
		axr(12'h120, 2'h0);
		chk(rd, 32'h1a);
		ask_mode <= 1'b1;
		repeat (100) @(posedge aclk);
		chk({24'h0, amp_setting_q}, 32'h40);
		tx_symbol <= 1'b1;
		axw(12'h088, 8'h17, 2'h0);
		repeat (100) @(posedge aclk);
		chk({24'h0, amp_setting_q}, 32'h47);
		tx_active <= 1'b0;
		repeat (100) @(posedge aclk);
		chk({23'h0, amp_enable_q, amp_setting_q}, 32'h40);
		// Calibration with the pump stage off, then on
		cal_pump_result <= 4'h3;
		cal_vco_result <= 6'h15;
		cal_cap_result <= 6'h2a;
		for (i = 0; i < 2; i++) begin
			axw(12'h08c, (i == 1) ? 8'ha9 : 8'h49, 2'h0);
			cal_start <= 1'b1;
			@(posedge aclk);
			cal_start <= 1'b0;
			repeat (3) @(posedge aclk);
			chk({31'h0, cal_busy_q}, 32'h1);
			for (n = 0; n < 400 && cal_busy_q !== 1'b0; n++) @(posedge aclk);
			if (n == 400) hung();
			repeat (3) @(posedge aclk);
			chk({28'h0, pump_current_q}, (i == 1) ? 32'h3 : 32'h9);
			chk({26'h0, vco_current_q}, 32'h15);
			chk({26'h0, vco_capacitor_q}, 32'h2a);
			chk({30'h0, synth_cal_config_q}, (i == 1) ? 32'h2 : 32'h1);
		end
		// Saved results written back in place of a calibration
		axw(12'h08c, 8'ha5, 2'h0);
		axw(12'h094, 8'h11, 2'h0);
		axw(12'h090, 8'h2c, 2'h0);
		repeat (2) @(posedge aclk);
		chk({28'h0, pump_current_q}, 32'h5);
		chk({26'h0, vco_capacitor_q}, 32'h11);
		chk({25'h0, vco_high_core_select_q, vco_current_q}, 32'h6c);
		wrap_up();
	end
endmodule : tb
